// >>> common/omc_pkg.sv
// shared constants and types for the operating-mode wake controller
package omc_pkg;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_MODE = 8'h00;
   localparam logic [7:0] OFF_WDOG = 8'h04;
   localparam logic [7:0] OFF_WAKE = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0C;

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int MODE_HIGH_SEL = 0;
   localparam int MODE_IDLE_EN = 1;
   localparam int MODE_HTO = 2;
   localparam int MODE_LTO = 3;
   localparam int MODE_FAST = 4;
   localparam int MODE_DIV_LSB = 5;
   localparam logic [7:0] MODE_RESET = 8'h03;
   localparam int WDOG_KEEP_BIT = 7;
   localparam logic [7:0] WDOG_RESET = 8'h7A;
   localparam logic [3:0] WDOG_OFF_CODE = 4'hA;
   localparam logic [7:0] WAKE_RESET = 8'h00;
   localparam logic [2:0] DIV_LOW_MAX = 3'h1;
   localparam logic [2:0] DIV_HIGH_MIN = 3'h2;
   localparam int STAT_PDF = 0;
   localparam int STAT_TO = 1;
   localparam int STAT_MODE_LSB = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int LOW_INTERNAL_RC_OSC_PERIOD_NS = 31250;
   localparam int LOW_INTERNAL_RC_OSC_CYCLES = LOW_INTERNAL_RC_OSC_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [10:0] HXT_READY_CYC = 11'h400;
   localparam logic [10:0] RC_READY_CYC = 11'h010;
   localparam logic [1:0] LOW_INTERNAL_RC_OSC_READY_TICKS = 2'h2;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      osc_crystal,
      osc_ext_rc,
      osc_int_rc
   } omc_osc_t;

   typedef enum logic [2:0] {
      mode_run,
      mode_deep_sleep,
      mode_light_sleep,
      mode_idle_no_sysclk,
      mode_idle_with_sysclk
   } omc_mode_t;

endpackage : omc_pkg

// >>> dv/omc_core_model.sv
// core and wake-source model facing the operating-mode controller
`timescale 1ns/1ps
module omc_core_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // requests from the bench
   input wire logic halt_req,
   input wire logic fall_req,
   input wire logic irq_set,
   input wire logic [2:0] pin_sel,
   // answer from the controller
   input wire logic irq_service,
   // core and pin outputs
   output logic halt_exec,
   output logic [7:0] port_a_in,
   output logic [7:0] irq_req
);
   // pins sit on pull-ups; a flag stays pending until it is served
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         halt_exec <= 1'b0;
         port_a_in <= 8'hFF;
         irq_req <= 8'h00;
      end else begin
         halt_exec <= halt_req;
         port_a_in <= fall_req ? ~(8'h01 << pin_sel) : 8'hFF;
         if (irq_service) begin
            irq_req <= 8'h00;
         end else if (irq_set) begin
            irq_req <= irq_req | (8'h01 << pin_sel);
         end
      end
   end
endmodule : omc_core_model

// >>> dv/testbench.sv
// self-checking bench for the operating-mode controller
`timescale 1ns/1ps
module testbench;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, irq_en = 8'hFF;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, clr_wdt = 1'b0, lvd_on = 1'b0;
   logic halt_req = 1'b0, fall_req = 1'b0, irq_set = 1'b0;
   logic wdt_ovf = 1'b0, ext_rst = 1'b0;
   logic [2:0] pin_sel = 3'h0, k;
   logic awready, wready, bvalid, arready, rvalid, halt_exec;
   logic irq_service, resume_next, wdt_reset, sys_reset;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] port_a_in, irq_req;
   logic [3:0] pv;
   logic [33:0] bus_q[$];
   logic [3:0] pul_q[$];
   int n_mismatch = 0, checks_done = 0, i;
   assign pv = {irq_service, resume_next, wdt_reset, sys_reset};
   always #2 aclk = ~aclk;

   omc_top #(.LOW_INTERNAL_RC_OSC_DIV(8)) dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .halt_exec(halt_exec), .clr_wdt(clr_wdt), .wdt_overflow(wdt_ovf),
      .ext_reset(ext_rst), .stack_full(1'b0), .irq_req(irq_req),
      .irq_en(irq_en), .port_a_in(port_a_in),
      .osc_type(omc_pkg::osc_int_rc), .wdt_cfg_en(1'b0),
      .wdt_src_sub(1'b1), .lvd_on(lvd_on), .sys_clk_en(),
      .sys_from_low(), .hosc_run(), .losc_run(), .tb_clk_run(),
      .wdt_clk_run(), .cpu_run(), .high_osc_ready(), .low_osc_ready(),
      .wdt_clear(), .resume_next(resume_next), .irq_service(irq_service),
      .sys_reset(sys_reset), .wdt_reset(wdt_reset));

   omc_core_model core_u (.aclk(aclk), .aresetn(aresetn),
      .halt_req(halt_req), .fall_req(fall_req), .irq_set(irq_set),
      .pin_sel(pin_sel), .irq_service(irq_service),
      .halt_exec(halt_exec), .port_a_in(port_a_in), .irq_req(irq_req));

   // -----------------------------------------------------------------
   // bus, event and compare tasks
   // -----------------------------------------------------------------
   task automatic cmp(input logic [33:0] e, input logic [33:0] g);
      checks_done++;
      if (e !== g) begin
         n_mismatch++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      bus_q.push_back({omc_pkg::RESP_OKAY, 32'h0});
      do @(posedge aclk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      bus_q.push_back(e);
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd

   // src 0 port fall, 1 interrupt, 2 watchdog overflow, 3 external reset
   task automatic wake(input int src, input logic [2:0] p,
                       input logic [3:0] e);
      if (e != 4'h0) begin
         pul_q.push_back(e);
      end
      pin_sel <= p;
      fall_req <= (src == 0);
      irq_set <= (src == 1);
      wdt_ovf <= (src == 2);
      ext_rst <= (src == 3);
      @(posedge aclk);
      fall_req <= 1'b0;
      irq_set <= 1'b0;
      wdt_ovf <= 1'b0;
      ext_rst <= 1'b0;
      repeat (5) @(posedge aclk);
   endtask : wake

   task automatic halt;
      halt_req <= 1'b1;
      @(posedge aclk);
      halt_req <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask : halt

   task automatic results;
      n_mismatch += pul_q.size() + bus_q.size();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results

   // results are matched to notes in the order they were made
   always @(posedge aclk) begin
      if ((bvalid & bready) === 1'b1) begin
         cmp(bus_q.pop_front(), {bresp, 32'h0});
      end
      if ((rvalid & rready) === 1'b1) begin
         cmp(bus_q.pop_front(), {rresp, rdata});
      end
      if ((|pv) === 1'b1) begin
         cmp({30'h0, pul_q.pop_front()}, {30'h0, pv});
      end
   end

   initial begin
      void'($urandom(3388));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(omc_pkg::OFF_MODE, {24'h0, omc_pkg::MODE_RESET});
      rd(8'h10, {omc_pkg::RESP_SLVERR, 32'h0});
      for (i = 0; i < 4; i++) begin
         k = 3'($urandom_range(7));
         lvd_on <= (i == 1);
         wr(omc_pkg::OFF_WDOG, {i[0], 7'h7A});
         wr(omc_pkg::OFF_MODE, {6'h0, i[1], 1'b1});
         wr(omc_pkg::OFF_WAKE, 8'h01 << k);
         halt();
         wake(0, k ^ 3'h1, 4'h0);
         rd(omc_pkg::OFF_STAT, {27'h0, 3'(i + 1), 4'h1});
         wake(0, k, 4'h4);
         rd(omc_pkg::OFF_STAT, 34'h1);
      end
      rd(omc_pkg::OFF_MODE, 34'h0F);
      halt();
      wake(2, 3'h0, 4'h2);
      rd(omc_pkg::OFF_STAT, 34'h3);
      clr_wdt <= 1'b1;
      @(posedge aclk);
      clr_wdt <= 1'b0;
      rd(omc_pkg::OFF_STAT, 34'h0);
      halt();
      wake(3, 3'h0, 4'h1);
      irq_en <= 8'h00;
      halt();
      wake(1, 3'h0, 4'h4);
      irq_en <= 8'hFF;
      halt();
      wake(0, k, 4'h4);
      halt();
      wake(1, 3'h1, 4'h8);
      results();
   end

   // a hang is cut short well past the expected run length
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      results();
   end
endmodule : testbench

// >>> src/omc_top.sv
// operating-mode controller: clock select, halt modes, wake-up, flags
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// How it works
// [R1] select low and divider 000/001 runs system clock from slow oscillator
// [R2] select high, or divider 010..111, returns to high-speed oscillator
// [R3] running from slow clock stops high oscillator and its divided clocks
// [R4] switch into slow mode waits for low-oscillator-ready, readable by software
// [R5] software checks high-oscillator-ready before relying on high clock
// [R6] halt, idle off, watchdog and detector off: deep sleep, all stopped
// [R7] halt, idle off, watchdog or detector on: light sleep on sub clock
// [R8] light sleep: enabled sub-clocked watchdog cleared and keeps counting
// [R9] halt, idle on, clock-keep off: system clock stops, time base runs
// [R10] that idle: sub-clocked watchdog runs, system-clocked watchdog stops
// [R11] halt, idle on, clock-keep on: all clocks run, execution stops
// [R12] that idle: enabled watchdog cleared and runs from either source
// [R13] any halt mode sets power-down flag, clears timeout, holds state
// [R14] wake on external reset, port A fall, interrupt, watchdog overflow
// [R15] reset wake gives full reset; watchdog wake gives watchdog reset
// [R16] power-down flag cleared by power-up or watchdog clear, set by halt
// [R17] watchdog timeout asleep sets timeout flag, resets only pc and sp
// [R18] per-pin wake mask on port A falls; resume after halt
// [R19] disabled interrupt or full stack wake resumes after halt
// [R20] enabled interrupt with stack room takes normal interrupt response
// [R21] interrupt already flagged at halt cannot wake the device
// [R22] divider 000/001 slow clock, 010..111 high clock over 64..2
// [R23] high ready after 1024 crystal cycles or 16 rc cycles
// [R24] low ready after two slow-oscillator cycles
// [R25] fast wake with crystal runs from sub clock until crystal ready
// [R26] clock switches land on a clock boundary; halt acts when taken
module omc_top #(
   parameter int unsigned LOW_INTERNAL_RC_OSC_DIV = omc_pkg::LOW_INTERNAL_RC_OSC_CYCLES
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // core events and wake sources
   input wire logic halt_exec,
   input wire logic clr_wdt,
   input wire logic wdt_overflow,
   input wire logic ext_reset,
   input wire logic stack_full,
   input wire logic [7:0] irq_req,
   input wire logic [7:0] irq_en,
   input wire logic [7:0] port_a_in,
   // configuration options
   input wire omc_pkg::omc_osc_t osc_type,
   input wire logic wdt_cfg_en,
   input wire logic wdt_src_sub,
   input wire logic lvd_on,
   // clock controls
   output logic sys_clk_en,
   output logic sys_from_low,
   output logic hosc_run,
   output logic losc_run,
   output logic tb_clk_run,
   output logic wdt_clk_run,
   output logic cpu_run,
   output logic high_osc_ready,
   output logic low_osc_ready,
   // wake and reset pulses
   output logic wdt_clear,
   output logic resume_next,
   output logic irq_service,
   output logic sys_reset,
   output logic wdt_reset
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [2:0] div_sel_ff;
   logic fast_en_ff, idle_en_ff, high_sel_ff;
   logic [7:0] wdog_ff, wake_mask_ff;
   logic pdf_ff, to_ff;
   omc_pkg::omc_mode_t mode_ff, nxt_mode, entry_mode;
   logic eff_high_ff, fast_ff;
   logic [2:0] eff_div_ff;
   logic [15:0] low_internal_rc_osc_cnt_ff;
   logic [1:0] lto_cnt_ff;
   logic lto_ff, hto_ff;
   logic [10:0] hto_cnt_ff;
   logic [5:0] div_cnt_ff;
   logic [7:0] stale_ff, port_prev_ff;
   logic wdt_clear_ff, resume_ff, service_ff, sys_reset_ff, wdt_reset_ff;
   logic bvalid_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;

   // slow-clock decode shared by request and applied selection
   function automatic logic sel_is_low(input logic high,
                                       input logic [2:0] div);
      return !high && (div <= omc_pkg::DIV_LOW_MAX);
   endfunction : sel_is_low

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire wdt_enabled = wdt_cfg_en ||
                      (wdog_ff[3:0] != omc_pkg::WDOG_OFF_CODE);
   wire low_power = (mode_ff != omc_pkg::mode_run);
   wire req_low = sel_is_low(high_sel_ff, div_sel_ff); // R22
   wire eff_low = sel_is_low(eff_high_ff, eff_div_ff); // R1
   wire osc_stopped = (mode_ff == omc_pkg::mode_deep_sleep) ||
                      (mode_ff == omc_pkg::mode_light_sleep) ||
                      (mode_ff == omc_pkg::mode_idle_no_sysclk);
   wire sysclk_on = (mode_ff == omc_pkg::mode_run) ||
                    (mode_ff == omc_pkg::mode_idle_with_sysclk);
   wire low_internal_rc_osc_tick = losc_run && (low_internal_rc_osc_cnt_ff == 16'(LOW_INTERNAL_RC_OSC_DIV - 1));
   wire [5:0] div_mask = 6'h3F >> (eff_div_ff - omc_pkg::DIV_HIGH_MIN);
   wire div_hit = ((div_cnt_ff & div_mask) == div_mask); // R22
   wire [10:0] hto_limit = (osc_type == omc_pkg::osc_crystal) ?
                           omc_pkg::HXT_READY_CYC : omc_pkg::RC_READY_CYC;
   wire sel_ready = req_low ? lto_ff : hto_ff; // R4
   wire halt_go = halt_exec && !low_power; // R26
   wire [7:0] new_irq = irq_req & ~stale_ff; // R21
   wire porta_wake = |(port_prev_ff & ~port_a_in & wake_mask_ff); // R18
   wire irq_wake = |new_irq;
   wire irq_ok = (|(new_irq & irq_en)) && !stack_full; // R20
   wire wdt_wake = low_power && !ext_reset && wdt_overflow; // R17
   wire plain_wake = low_power && !ext_reset && !wdt_overflow &&
                     (porta_wake || irq_wake); // R14
   wire fast_arm = (mode_ff == omc_pkg::mode_light_sleep ||
                    mode_ff == omc_pkg::mode_idle_no_sysclk) &&
                   (plain_wake || wdt_wake) && fast_en_ff &&
                   (osc_type == omc_pkg::osc_crystal) && !eff_low;

   // halt target from idle, clock-keep and watchdog/detector state
   assign entry_mode = idle_en_ff ?
      (wdog_ff[omc_pkg::WDOG_KEEP_BIT] ? omc_pkg::mode_idle_with_sysclk
                                       : omc_pkg::mode_idle_no_sysclk)
      : ((wdt_enabled || lvd_on) ? omc_pkg::mode_light_sleep
                                 : omc_pkg::mode_deep_sleep);

   // clock gating outputs follow the current mode
   assign hosc_run = !osc_stopped && !(eff_low && req_low && !fast_ff); // R3
   assign losc_run = (mode_ff != omc_pkg::mode_deep_sleep); // R6
   assign tb_clk_run = (mode_ff != omc_pkg::mode_deep_sleep) &&
                       (mode_ff != omc_pkg::mode_light_sleep); // R9
   assign cpu_run = !low_power;
   assign sys_from_low = eff_low || fast_ff; // R25
   assign sys_clk_en = sysclk_on &&
      (sys_from_low ? low_internal_rc_osc_tick : (eff_high_ff || div_hit)); // R22
   assign high_osc_ready = hto_ff;
   assign low_osc_ready = lto_ff;

   // watchdog clock per mode; a system-clocked watchdog needs sysclk
   always_comb begin
      unique case (mode_ff)
         omc_pkg::mode_run: wdt_clk_run = wdt_enabled;
         omc_pkg::mode_deep_sleep: wdt_clk_run = 1'b0; // R6
         omc_pkg::mode_light_sleep: wdt_clk_run = wdt_enabled && wdt_src_sub; // R8
         omc_pkg::mode_idle_no_sysclk: wdt_clk_run = wdt_enabled && wdt_src_sub; // R10
         omc_pkg::mode_idle_with_sysclk: wdt_clk_run = wdt_enabled; // R12
         default: wdt_clk_run = 1'b0;
      endcase
   end

   // mode sequencing; a reset wake beats a watchdog wake beats the rest
   always_comb begin
      nxt_mode = mode_ff;
      if (ext_reset || wdt_wake || plain_wake) begin
         nxt_mode = omc_pkg::mode_run; // R14
      end else if (halt_go) begin
         nxt_mode = entry_mode; // R6 R7 R9 R11
      end
   end

   // ---------------------------------------------------------------
   // oscillators and dividers
   // ---------------------------------------------------------------
   // slow oscillator period and its ready count
   always_ff @(posedge aclk) begin
      if (!aresetn || !losc_run || low_internal_rc_osc_tick) begin
         low_internal_rc_osc_cnt_ff <= 16'h0000;
      end else begin
         low_internal_rc_osc_cnt_ff <= low_internal_rc_osc_cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !losc_run) begin
         lto_cnt_ff <= 2'h0;
         lto_ff <= 1'b0;
      end else if (low_internal_rc_osc_tick && !lto_ff) begin
         lto_cnt_ff <= lto_cnt_ff + 2'h1;
         lto_ff <= (lto_cnt_ff + 2'h1 == omc_pkg::LOW_INTERNAL_RC_OSC_READY_TICKS); // R24
      end
   end

   // high oscillator settles for an oscillator-type count after start
   always_ff @(posedge aclk) begin
      if (!aresetn || !hosc_run) begin
         hto_cnt_ff <= 11'h000;
         hto_ff <= 1'b0;
      end else if (!hto_ff) begin
         hto_cnt_ff <= hto_cnt_ff + 11'h001;
         hto_ff <= (hto_cnt_ff + 11'h001 == hto_limit); // R23
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt_ff <= 6'h00;
      end else begin
         div_cnt_ff <= div_cnt_ff + 6'h01;
      end
   end

   // applied selection moves only on a system clock edge, once the
   // target oscillator is ready, so no runt period reaches the core
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         eff_high_ff <= omc_pkg::MODE_RESET[omc_pkg::MODE_HIGH_SEL];
         eff_div_ff <= omc_pkg::MODE_RESET[omc_pkg::MODE_DIV_LSB +: 3];
      end else if (sys_clk_en && sel_ready && !fast_ff) begin
         eff_high_ff <= high_sel_ff; // R2 R26
         eff_div_ff <= div_sel_ff; // R1
      end
   end

   // fast wake: sub clock carries the system until the crystal is ready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fast_ff <= 1'b0;
      end else if (fast_arm) begin
         fast_ff <= 1'b1; // R25
      end else if (hto_ff) begin
         fast_ff <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // mode, flags and wake pulses
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_ff <= omc_pkg::mode_run;
         stale_ff <= 8'h00;
         port_prev_ff <= 8'h00;
      end else begin
         mode_ff <= nxt_mode;
         stale_ff <= halt_go ? irq_req : stale_ff; // R21
         port_prev_ff <= port_a_in;
      end
   end

   // flags: a set in the same cycle as a clear wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pdf_ff <= 1'b0; // R16
         to_ff <= 1'b0;
      end else begin
         if (halt_go) begin
            pdf_ff <= 1'b1; // R13 R16
         end else if (clr_wdt) begin
            pdf_ff <= 1'b0; // R16
         end
         if (wdt_overflow) begin
            to_ff <= 1'b1; // R17
         end else if (halt_go || clr_wdt) begin
            to_ff <= 1'b0; // R13
         end
      end
   end

   // one-cycle results of halt and wake events
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdt_clear_ff <= 1'b0;
         resume_ff <= 1'b0;
         service_ff <= 1'b0;
         sys_reset_ff <= 1'b0;
         wdt_reset_ff <= 1'b0;
      end else begin
         wdt_clear_ff <= halt_go; // R6 R8 R12
         service_ff <= plain_wake && irq_wake && irq_ok; // R20
         resume_ff <= plain_wake && !(irq_wake && irq_ok); // R18 R19
         sys_reset_ff <= ext_reset || (!low_power && wdt_overflow); // R15
         wdt_reset_ff <= wdt_wake; // R15 R17
      end
   end

   assign wdt_clear = wdt_clear_ff;
   assign resume_next = resume_ff;
   assign irq_service = service_ff;
   assign sys_reset = sys_reset_ff;
   assign wdt_reset = wdt_reset_ff;

   // ---------------------------------------------------------------
   // axi4-lite slave
   // ---------------------------------------------------------------
   // both write channels are taken together in one cycle
   wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
   wire rd_go = s_axi_arvalid && !rvalid_ff;
   wire wr_mode = (s_axi_awaddr == omc_pkg::OFF_MODE);
   wire wr_wdog = (s_axi_awaddr == omc_pkg::OFF_WDOG);
   wire wr_wake = (s_axi_awaddr == omc_pkg::OFF_WAKE);
   wire wr_hit = wr_mode || wr_wdog || wr_wake ||
                 (s_axi_awaddr == omc_pkg::OFF_STAT);
   wire wr_lane = wr_go && s_axi_wstrb[0];
   wire [7:0] mode_rd = {div_sel_ff, fast_en_ff, lto_ff, hto_ff,
                         idle_en_ff, high_sel_ff}; // R4 R5
   wire [7:0] stat_rd = {1'b0, 3'(mode_ff), 2'b00, to_ff, pdf_ff};

   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;

   // software-written controls
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         high_sel_ff <= omc_pkg::MODE_RESET[omc_pkg::MODE_HIGH_SEL];
         idle_en_ff <= omc_pkg::MODE_RESET[omc_pkg::MODE_IDLE_EN];
         fast_en_ff <= omc_pkg::MODE_RESET[omc_pkg::MODE_FAST];
         div_sel_ff <= omc_pkg::MODE_RESET[omc_pkg::MODE_DIV_LSB +: 3];
         wdog_ff <= omc_pkg::WDOG_RESET;
         wake_mask_ff <= omc_pkg::WAKE_RESET;
      end else if (wr_lane) begin
         if (wr_mode) begin
            high_sel_ff <= s_axi_wdata[omc_pkg::MODE_HIGH_SEL];
            idle_en_ff <= s_axi_wdata[omc_pkg::MODE_IDLE_EN];
            fast_en_ff <= s_axi_wdata[omc_pkg::MODE_FAST];
            div_sel_ff <= s_axi_wdata[omc_pkg::MODE_DIV_LSB +: 3];
         end
         if (wr_wdog) begin
            wdog_ff <= s_axi_wdata[7:0];
         end
         if (wr_wake) begin
            wake_mask_ff <= s_axi_wdata[7:0];
         end
      end
   end

   // write response; unmapped offsets answer slverr
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= omc_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_hit ? omc_pkg::RESP_OKAY : omc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // read data; registers are 8 bits, upper bits read zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rresp_ff <= omc_pkg::RESP_OKAY;
         rdata_ff <= 32'h0000_0000;
      end else if (rd_go) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= omc_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            omc_pkg::OFF_MODE: rdata_ff <= {24'h000000, mode_rd};
            omc_pkg::OFF_WDOG: rdata_ff <= {24'h000000, wdog_ff};
            omc_pkg::OFF_WAKE: rdata_ff <= {24'h000000, wake_mask_ff};
            omc_pkg::OFF_STAT: rdata_ff <= {24'h000000, stat_rd};
            default: begin
               rdata_ff <= 32'h0000_0000;
               rresp_ff <= omc_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   halt_flags_a: assert property ( // R13
      halt_go && !wdt_overflow |=> pdf_ff && !to_ff && wdt_clear)
      else $error("halt did not set pdf and clear timeout");
   deep_entry_a: assert property ( // R6
      halt_go && !ext_reset && !idle_en_ff && !wdt_enabled && !lvd_on
      |=> mode_ff == omc_pkg::mode_deep_sleep && !losc_run && !wdt_clk_run)
      else $error("deep sleep entry or clock stop wrong");
   light_clk_a: assert property ( // R7
      mode_ff == omc_pkg::mode_light_sleep |->
      !sys_clk_en && !tb_clk_run && losc_run &&
      (wdt_clk_run == (wdt_enabled && wdt_src_sub)))
      else $error("light sleep clocks wrong");
   idle_no_sysclk_clk_a: assert property ( // R9
      mode_ff == omc_pkg::mode_idle_no_sysclk |->
      !sys_clk_en && tb_clk_run && !hosc_run &&
      (wdt_clk_run == (wdt_enabled && wdt_src_sub)))
      else $error("idle without sysclk clocks wrong");
   idle_with_sysclk_clk_a: assert property ( // R11
      mode_ff == omc_pkg::mode_idle_with_sysclk |->
      !cpu_run && tb_clk_run && wdt_clk_run == wdt_enabled)
      else $error("idle with sysclk clocks wrong");
   wdt_wake_a: assert property ( // R17
      low_power && wdt_overflow && !ext_reset |=>
      to_ff && wdt_reset && !sys_reset && mode_ff == omc_pkg::mode_run)
      else $error("watchdog wake handling wrong");
   porta_wake_a: assert property ( // R18
      low_power && porta_wake && !irq_wake && !ext_reset && !wdt_overflow
      |=> resume_next && !irq_service ##1 !resume_next)
      else $error("port wake did not resume once");
   stale_irq_a: assert property ( // R21
      low_power && irq_req == stale_ff && !porta_wake && !ext_reset &&
      !wdt_overflow |=> !resume_next && !irq_service)
      else $error("stale interrupt woke the device");
   slow_ready_a: assert property ( // R4
      $rose(eff_low) |-> $past(lto_ff))
      else $error("slow clock applied before low oscillator ready");
   hosc_stop_a: assert property ( // R3
      eff_low && req_low && !fast_ff |-> !hosc_run ##1 !hto_ff)
      else $error("high oscillator left running in slow mode");

   deep_cover_c: cover property (halt_go ##1
      mode_ff == omc_pkg::mode_deep_sleep ##[1:20] resume_next);
   service_cover_c: cover property (irq_service);
   wdt_wake_cover_c: cover property (wdt_reset);
   slow_cover_c: cover property ($rose(eff_low));

endmodule : omc_top
